// ===== pkg/dpllc_defs.svh
`ifndef DPLLC_DEFS_SVH
`define DPLLC_DEFS_SVH
// Summary of operation
// RULE1 - Free run: DCO frequency is fsys*2/(8+word/2^30) from 32-bit word.
// RULE2 - Output frequency may be trimmed about +/-100 ppm without opening loop.
// RULE3 - Divider writes take effect only after 0x01 written to offset 0x0005.
// RULE4 - Numerator-only update applies without holdover, once per detector sample.
// RULE5 - Integer or modulus change causes a brief automatic holdover blip.
// RULE6 - Lock accumulators saturate between -2048 empty and +2048 full.
// RULE7 - Below -1024 unlocked, above +1024 locked, otherwise hold indication.
// RULE8 - Fill and drain step sizes are 8-bit programmable values.
// RULE9 - Each sample adds fill if magnitude within threshold, else subtracts drain.
// RULE10 - Phase threshold is 24-bit picoseconds against phase error magnitude.
// RULE11 - Entering free run or holdover forces phase lock indication unlocked.
// RULE12 - Lock indications are preserved across a reference switchover.
// RULE13 - Frequency detector works alike but uses reference-feedback period difference.
// RULE14 - Frequency threshold is 24-bit picoseconds against period difference magnitude.
// RULE15 - Loop filter tuning word is clamped to a programmable range.
// RULE16 - Tuning word averaged over programmable interval; average used in holdover.
// RULE17 - Switchover: brief holdover, load new reference parameters, return closed.
// RULE18 - Holdover, automatic or user requested, keeps output frequency constant.
// RULE19 - Valid reference during holdover closes loop using that reference's profile.
// RULE20 - User holdover bit keeps holdover despite valid reference until cleared.
// RULE21 - Integer, numerator, modulus registers exist per reference, three bytes each.
// RULE22 - Output equals detector frequency times (17-bit int+1 + 23-bit frac/mod).
// RULE23 - Host changes modulus from zero to nonzero only while in free run.
// RULE24 - After reset accumulators are empty and both lock indications unlocked.

// Register indices; byte address is four times the index
`define DPLLC_IDX_UPDATE 14'h0005
`define DPLLC_IDX_FREE_RUN_TUNING_WORD 14'h0400
`define DPLLC_IDX_INT0 14'h0444
`define DPLLC_IDX_FEEDBACK_FRACTION_NUMERATOR 14'h0447
`define DPLLC_IDX_FEEDBACK_FRACTION_MODULUS 14'h044A
`define DPLLC_IDX_FTW1 14'h0500
`define DPLLC_REF_STRIDE 14'h0020
`define DPLLC_IDX_CTRL 14'h0A00
`define DPLLC_IDX_PTHR 14'h0A01
`define DPLLC_IDX_FTHR 14'h0A02
`define DPLLC_IDX_RATES 14'h0A03
`define DPLLC_IDX_CLAMPLO 14'h0A04
`define DPLLC_IDX_CLAMPHI 14'h0A05
`define DPLLC_IDX_HIST 14'h0A06
`define DPLLC_IDX_STATUS 14'h0A07
`define DPLLC_UPDATE_CMD 8'h01
// Control bits
`define DPLLC_CTRL_HOLD 0
`define DPLLC_CTRL_FREE 1
`define DPLLC_CTRL_SEL 2
// Reset values
`define DPLLC_FTW_RST 32'h0000_0000
`define DPLLC_CTRL_RST 4'h2
`define DPLLC_CLAMPLO_RST 32'h0000_0000
`define DPLLC_CLAMPHI_RST 32'hFFFF_FFFF
`define DPLLC_HIST_RST 4'h8
// Accumulator levels, 14-bit signed
`define DPLLC_ACC_EMPTY 14'h3800
`define DPLLC_ACC_FULL 14'h0800
`define DPLLC_ACC_LOW 14'h3C00
`define DPLLC_ACC_HIGH 14'h0400
// Last blip counter value; a holdover blip lasts 5 clocks
`define DPLLC_BLIP_CYCLES 4'h4
`endif

// ===== pkg/dpllc_pkg.sv
package dpllc_pkg;
  typedef struct packed {
    logic valid;
    logic signed [23:0] phaseErr;
    logic signed [23:0] periodDiff;
  } dpllc_sample_t;
  typedef struct packed {
    logic [16:0] intDiv;
    logic [22:0] fracNum;
    logic [22:0] fracMod;
  } dpllc_div_t;
  typedef enum logic [2:0] {
    FREE_RUN, CLOSED, HOLDOVER, SWITCHING, BLIP
  } dpllc_state_t;
endpackage

// ===== hw/dpllc_loop_ctrl.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "dpllc_defs.svh"
module dpllc_loop_ctrl #(
  parameter int NREF = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Loop datapath
  input wire dpllc_pkg::dpllc_sample_t sample,
  input wire logic [31:0] loopWord,
  input wire logic [NREF-1:0] refValid,
  // Controls to the oscillator and divider, and loop status
  output logic [31:0] dcoWord,
  output logic [31:0] freeRunWord1,
  output dpllc_pkg::dpllc_div_t activeDiv,
  output logic [1:0] activeRef,
  output dpllc_pkg::dpllc_state_t loopState,
  output logic phaseLock,
  output logic freqLock
);
  import dpllc_pkg::*;

  // ==========================================================
  // Register storage
  logic [31:0] free_run_tuning_word;
  logic [31:0] ftw1;
  logic [3:0] ctrl;
  logic [23:0] phaseThr;
  logic [23:0] freqThr;
  logic [31:0] rates;
  logic [31:0] clampLo;
  logic [31:0] clampHi;
  logic [3:0] histShift;
  dpllc_div_t staged [NREF];
  dpllc_div_t committed [NREF];
  logic commitPulse;
  logic checkPulse;
  logic pendBig;
  logic pendFrac;
  logic [3:0] blipCnt;
  logic rdErr;
  logic [31:0] histAvg;
  logic histValid;
  logic [31:0] lastWord;
  logic signed [13:0] acc [2];
  logic [1:0] lockFlag;

  // ==========================================================
  // Address decode
  function automatic logic [4:0] divDecode(input logic [13:0] idx);
    logic [13:0] off;
    logic [4:0] res;
    res = 5'h00;
    off = 14'h0000;
    for (int r = 0; r < NREF; r++) begin
      off = idx - (`DPLLC_IDX_INT0 + 14'(r) * `DPLLC_REF_STRIDE);
      if (off == 14'h0000) begin
        res = {1'b1, 2'h0, 2'(r)};
      end else if (off == `DPLLC_IDX_FEEDBACK_FRACTION_NUMERATOR - `DPLLC_IDX_INT0) begin
        res = {1'b1, 2'h1, 2'(r)};
      end else if (off == `DPLLC_IDX_FEEDBACK_FRACTION_MODULUS - `DPLLC_IDX_INT0) begin
        res = {1'b1, 2'h2, 2'(r)};
      end
    end
    return res;
  endfunction

  function automatic logic [23:0] magnitude(input logic signed [23:0] v);
    return v[23] ? 24'(-v) : 24'(v);
  endfunction

  logic [13:0] index;
  logic [4:0] dec;
  logic wrEn;
  logic setup;
  logic [1:0] selRef;
  assign index = paddr[15:2];
  assign dec = divDecode(index);
  assign setup = psel & ~penable;
  assign wrEn = psel & penable & pwrite;
  assign pready = psel & penable;
  assign pslverr = pready & rdErr;
  assign selRef = ctrl[`DPLLC_CTRL_SEL +: 2];
  assign freeRunWord1 = ftw1;
  assign phaseLock = lockFlag[0];
  assign freqLock = lockFlag[1];

  // ==========================================================
  // Read path, captured in the setup cycle
  logic [31:0] next_rdata;
  logic next_err;
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (dec[4]) begin
      case (dec[3:2])
        2'h0: next_rdata = {15'h0000, staged[dec[1:0]].intDiv};
        2'h1: next_rdata = {9'h000, staged[dec[1:0]].fracNum};
        default: next_rdata = {9'h000, staged[dec[1:0]].fracMod};
      endcase
    end else begin
      case (index)
        `DPLLC_IDX_UPDATE: next_rdata = 32'h0000_0000;
        `DPLLC_IDX_FREE_RUN_TUNING_WORD: next_rdata = free_run_tuning_word;
        `DPLLC_IDX_FTW1: next_rdata = ftw1;
        `DPLLC_IDX_CTRL: next_rdata = {28'h0000000, ctrl};
        `DPLLC_IDX_PTHR: next_rdata = {8'h00, phaseThr};
        `DPLLC_IDX_FTHR: next_rdata = {8'h00, freqThr};
        `DPLLC_IDX_RATES: next_rdata = rates;
        `DPLLC_IDX_CLAMPLO: next_rdata = clampLo;
        `DPLLC_IDX_CLAMPHI: next_rdata = clampHi;
        `DPLLC_IDX_HIST: next_rdata = {28'h0000000, histShift};
        `DPLLC_IDX_STATUS: next_rdata = {24'h000000, histValid, loopState,
            activeRef, freqLock, phaseLock};
        default: next_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
      rdErr <= 1'b0;
    end else if (setup) begin
      prdata <= next_rdata;
      rdErr <= next_err;
    end
  end

  // ==========================================================
  // Writable registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      free_run_tuning_word <= `DPLLC_FTW_RST;
      ftw1 <= `DPLLC_FTW_RST;
      ctrl <= `DPLLC_CTRL_RST;
      phaseThr <= 24'h000000;
      freqThr <= 24'h000000;
      rates <= 32'h0000_0000;
      clampLo <= `DPLLC_CLAMPLO_RST;
      clampHi <= `DPLLC_CLAMPHI_RST;
      histShift <= `DPLLC_HIST_RST;
    end else if (wrEn && !dec[4]) begin
      case (index)
        `DPLLC_IDX_FREE_RUN_TUNING_WORD: free_run_tuning_word <= pwdata;
        `DPLLC_IDX_FTW1: ftw1 <= pwdata;
        `DPLLC_IDX_CTRL: ctrl <= pwdata[3:0];
        `DPLLC_IDX_PTHR: phaseThr <= pwdata[23:0]; // RULE10
        `DPLLC_IDX_FTHR: freqThr <= pwdata[23:0]; // RULE14
        `DPLLC_IDX_RATES: rates <= pwdata; // RULE8
        `DPLLC_IDX_CLAMPLO: clampLo <= pwdata;
        `DPLLC_IDX_CLAMPHI: clampHi <= pwdata;
        `DPLLC_IDX_HIST: histShift <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Divider staging and commit
  genvar g;
  generate
    for (g = 0; g < NREF; g++) begin : gDiv
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          staged[g] <= '0;
          committed[g] <= '0;
        end else begin
          if (wrEn && dec[4] && dec[1:0] == 2'(g)) begin // RULE21
            case (dec[3:2])
              2'h0: staged[g].intDiv <= pwdata[16:0];
              2'h1: staged[g].fracNum <= pwdata[22:0];
              default: staged[g].fracMod <= pwdata[22:0];
            endcase
          end
          if (commitPulse) begin
            committed[g] <= staged[g]; // RULE3
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      commitPulse <= 1'b0;
      checkPulse <= 1'b0;
    end else begin
      commitPulse <= wrEn && !dec[4] && index == `DPLLC_IDX_UPDATE
          && pwdata[7:0] == `DPLLC_UPDATE_CMD; // RULE3
      checkPulse <= commitPulse;
    end
  end

  // ==========================================================
  // Change detection on committed dividers
  dpllc_div_t newDiv;
  logic bigChange;
  logic fracChange;
  logic loadNew;
  assign newDiv = committed[selRef];
  assign bigChange = newDiv.intDiv != activeDiv.intDiv
      || newDiv.fracMod != activeDiv.fracMod;
  assign fracChange = newDiv.fracNum != activeDiv.fracNum;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pendBig <= 1'b0;
      pendFrac <= 1'b0;
    end else begin
      if (checkPulse && bigChange && loopState == CLOSED) begin
        pendBig <= 1'b1; // RULE5
      end else if (loadNew) begin
        pendBig <= 1'b0;
      end
      if (checkPulse && !bigChange && fracChange) begin
        pendFrac <= 1'b1; // RULE4
      end else if (sample.valid || loadNew) begin
        pendFrac <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      activeDiv <= '0;
      activeRef <= 2'h0;
    end else if (loadNew) begin
      activeDiv <= newDiv; // RULE22
      activeRef <= selRef; // RULE19
    end else if (pendFrac && sample.valid) begin
      activeDiv.fracNum <= newDiv.fracNum; // RULE2 RULE4
    end else if (checkPulse && loopState == FREE_RUN) begin
      activeDiv <= newDiv; // RULE23
    end
  end

  // ==========================================================
  // Loop state machine
  logic userHold;
  logic userFree;
  logic refOk;
  assign userHold = ctrl[`DPLLC_CTRL_HOLD];
  assign userFree = ctrl[`DPLLC_CTRL_FREE];
  assign refOk = refValid[selRef];

  dpllc_state_t next_state;
  always_comb begin
    next_state = loopState;
    loadNew = 1'b0;
    case (loopState)
      FREE_RUN: begin
        if (!userFree && !userHold && refOk) begin
          next_state = CLOSED;
          loadNew = 1'b1;
        end else if (!userFree) begin
          next_state = HOLDOVER;
        end
      end
      CLOSED: begin
        if (userFree) begin
          next_state = FREE_RUN;
        end else if (userHold || !refValid[activeRef]) begin
          next_state = HOLDOVER; // RULE18
        end else if (selRef != activeRef && refOk) begin
          next_state = SWITCHING; // RULE17
        end else if (pendBig) begin
          next_state = BLIP; // RULE5
        end
      end
      SWITCHING, BLIP: begin
        if (blipCnt == `DPLLC_BLIP_CYCLES) begin
          next_state = CLOSED;
          loadNew = 1'b1; // RULE17
        end
      end
      HOLDOVER: begin
        if (userFree) begin
          next_state = FREE_RUN;
        end else if (!userHold && refOk) begin // RULE20
          next_state = CLOSED;
          loadNew = 1'b1; // RULE19
        end
      end
      default: next_state = FREE_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      loopState <= FREE_RUN;
    end else begin
      loopState <= next_state;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      blipCnt <= 4'h0;
    end else if (loopState == SWITCHING || loopState == BLIP) begin
      blipCnt <= blipCnt + 4'h1;
    end else begin
      blipCnt <= 4'h0;
    end
  end

  // ==========================================================
  // Tuning word clamp and history
  logic [31:0] clamped;
  logic [47:0] histSum;
  logic [15:0] histCnt;
  logic [15:0] histLimit;
  logic [47:0] histTotal;
  assign clamped = loopWord < clampLo ? clampLo :
      (loopWord > clampHi ? clampHi : loopWord); // RULE15
  assign histLimit = (16'h0001 << histShift) - 16'h0001;
  assign histTotal = histSum + {16'h0000, clamped};

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      histSum <= 48'h0;
      histCnt <= 16'h0000;
      histAvg <= 32'h0000_0000;
      histValid <= 1'b0;
      lastWord <= 32'h0000_0000;
    end else if (loopState == CLOSED && sample.valid) begin
      lastWord <= clamped;
      if (histCnt >= histLimit) begin
        histAvg <= 32'(histTotal >> histShift); // RULE16
        histValid <= 1'b1;
        histSum <= 48'h0;
        histCnt <= 16'h0000;
      end else begin
        histSum <= histTotal;
        histCnt <= histCnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dcoWord <= `DPLLC_FTW_RST;
    end else begin
      case (loopState)
        FREE_RUN: dcoWord <= free_run_tuning_word; // RULE1
        CLOSED: dcoWord <= clamped; // RULE15
        default: dcoWord <= histValid ? histAvg : lastWord; // RULE16 RULE18
      endcase
    end
  end

  // ==========================================================
  // Phase (0) and frequency (1) lock detectors
  generate
    for (g = 0; g < 2; g++) begin : gLock
      logic [23:0] mag;
      logic [23:0] thr;
      logic [7:0] fill;
      logic [7:0] drain;
      logic signed [13:0] next_acc;
      assign mag = magnitude(g == 0 ? sample.phaseErr
          : sample.periodDiff); // RULE13
      assign thr = g == 0 ? phaseThr : freqThr;
      assign fill = rates[16 * g +: 8];
      assign drain = rates[16 * g + 8 +: 8];

      always_comb begin
        next_acc = acc[g];
        if (mag <= thr) begin // RULE9
          next_acc = acc[g] + $signed({6'h00, fill});
          if (next_acc > $signed(`DPLLC_ACC_FULL)) begin
            next_acc = $signed(`DPLLC_ACC_FULL); // RULE6
          end
        end else begin
          next_acc = acc[g] - $signed({6'h00, drain});
          if (next_acc < $signed(`DPLLC_ACC_EMPTY)) begin
            next_acc = $signed(`DPLLC_ACC_EMPTY); // RULE6
          end
        end
      end

      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          acc[g] <= $signed(`DPLLC_ACC_EMPTY); // RULE24
          lockFlag[g] <= 1'b0; // RULE24
        end else if (loopState == SWITCHING || loopState == BLIP) begin
          acc[g] <= acc[g]; // RULE12
          lockFlag[g] <= lockFlag[g];
        end else if (g == 0 && loopState != CLOSED) begin
          acc[g] <= $signed(`DPLLC_ACC_EMPTY); // RULE11
          lockFlag[g] <= 1'b0; // RULE11
        end else begin
          if (loopState == CLOSED && sample.valid) begin
            acc[g] <= next_acc;
          end
          if (acc[g] < $signed(`DPLLC_ACC_LOW)) begin
            lockFlag[g] <= 1'b0; // RULE7
          end else if (acc[g] > $signed(`DPLLC_ACC_HIGH)) begin
            lockFlag[g] <= 1'b1; // RULE7
          end
        end
      end
    end
  endgenerate

endmodule // dpllc_loop_ctrl

// ===== verification/dpllc_loop_ctrl_monitor.sv
`timescale 1ns/1ps
// ==========
// Loop state and lock checker
module dpllc_loop_ctrl_monitor #(
  parameter int NREF = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Loop side
  input wire dpllc_pkg::dpllc_sample_t sample,
  input wire logic [31:0] dcoWord,
  input wire dpllc_pkg::dpllc_state_t loopState,
  input wire logic phaseLock,
  input wire logic freqLock
);
  import dpllc_pkg::*;
  logic [3:0] nSamp;

  // Samples seen since reset, saturating
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      nSamp <= 4'h0;
    end else if (sample.valid && nSamp != 4'hF) begin
      nSamp <= nSamp + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence blip5;
    (loopState == BLIP) [*5] ##1 (loopState == CLOSED);
  endsequence
  sequence swap5;
    (loopState == SWITCHING) [*5] ##1 (loopState == CLOSED);
  endsequence

  a_zero_wait:
    assert property (psel && penable |-> pready)
    else $error("access cycle without ready");
  a_err_ready:
    assert property (pslverr |-> pready)
    else $error("error flag outside access");
  a_idle_unlock:
    assert property ((loopState inside {FREE_RUN, HOLDOVER}) [*2]
      |-> !phaseLock)
    else $error("phase lock shown while loop open");
  a_keep_locks:
    assert property (loopState inside {SWITCHING, BLIP} &&
      $past(loopState, 2) inside {SWITCHING, BLIP}
      |-> $stable(phaseLock) && $stable(freqLock))
    else $error("lock changed during transition");
  a_blip_length:
    assert property ($rose(loopState == BLIP) |-> blip5)
    else $error("divider holdover blip wrong length");
  a_switch_length:
    assert property ($rose(loopState == SWITCHING) |-> swap5)
    else $error("switchover wrong length");
  a_hold_const:
    assert property ((loopState == HOLDOVER) [*3] |-> $stable(dcoWord))
    else $error("tuning word moved in holdover");
  a_lock_cause:
    assert property ($rose(phaseLock) |-> $past(sample.valid) ||
      $past(sample.valid, 2) || $past(sample.valid, 3))
    else $error("lock rose without a sample");
  a_fill_count:
    assert property (phaseLock || freqLock |-> nSamp >= 4'hD)
    else $error("lock reached in too few samples");
endmodule // dpllc_loop_ctrl_monitor

bind dpllc_loop_ctrl dpllc_loop_ctrl_monitor #(.NREF(NREF)) u_monitor (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .sample(sample), .dcoWord(dcoWord),
  .loopState(loopState), .phaseLock(phaseLock), .freqLock(freqLock)
);

// ===== verification/dpllc_ref_source.sv
`timescale 1ns/1ps
// ==========
// Detector sample source
module dpllc_ref_source (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Bench control
  input wire logic enable,
  input wire logic [7:0] period,
  input wire logic [23:0] phaseMag,
  input wire logic [23:0] diffMag,
  // Samples
  output dpllc_pkg::dpllc_sample_t sample,
  output logic [31:0] count
);
  import dpllc_pkg::*;
  logic [7:0] gap;
  logic negSign;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gap <= 8'h00;
      negSign <= 1'b0;
      count <= 32'h0000_0000;
      sample <= '0;
    end else if (enable && gap >= period) begin
      gap <= 8'h00;
      negSign <= !negSign;
      count <= count + 32'h0000_0001;
      sample.valid <= 1'b1;
      sample.phaseErr <= negSign ? 24'h000000 - phaseMag : phaseMag;
      sample.periodDiff <= negSign ? 24'h000000 - diffMag : diffMag;
    end else begin
      // Data lines churn between samples
      gap <= gap + 8'h01;
      sample.valid <= 1'b0;
      sample.phaseErr <= ~sample.phaseErr;
      sample.periodDiff <= ~sample.periodDiff;
    end
  end
endmodule // dpllc_ref_source

// ===== verification/dpllc_loop_ctrl_bench.sv
`timescale 1ns/1ps
// ==========
// Loop controller bench
module dpllc_loop_ctrl_bench;
  import dpllc_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dpllc_sample_t sample;
  logic [31:0] loopWord = 32'h0000_0000;
  logic [3:0] refValid = 4'h0;
  logic [31:0] dcoWord;
  logic [31:0] freeRunWord1;
  dpllc_div_t activeDiv;
  logic [1:0] activeRef;
  dpllc_state_t loopState;
  logic phaseLock;
  logic freqLock;
  logic srcOn = 1'b0;
  logic [23:0] phaseMag = 24'h000064;
  logic [23:0] diffMag = 24'h000065;
  logic [31:0] srcCount;
  logic [31:0] rd;
  logic er;
  logic saw;
  logic [31:0] held;
  int miscompares = 0;
  int checksDone = 0;

  always #12.5 clk_sys = ~clk_sys;

  dpllc_loop_ctrl #(.NREF(4)) uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample(sample),
    .loopWord(loopWord), .refValid(refValid), .dcoWord(dcoWord),
    .freeRunWord1(freeRunWord1), .activeDiv(activeDiv),
    .activeRef(activeRef), .loopState(loopState), .phaseLock(phaseLock),
    .freqLock(freqLock)
  );

  dpllc_ref_source src (
    .clk_sys(clk_sys), .reset_n(reset_n), .enable(srcOn), .period(8'h04),
    .phaseMag(phaseMag), .diffMag(diffMag), .sample(sample),
    .count(srcCount)
  );

  // ==========
  // Tasks
  task automatic finalReport();
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [13:0] idx, input logic wr,
                      input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) miscompares++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [13:0] idx, input logic [31:0] wd);
    xfer(idx, 1'b1, wd);
  endtask

  task automatic waitState(input dpllc_state_t s);
    int n;
    n = 0;
    while (loopState !== s && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    cmp(loopState, s);
  endtask

  task automatic samples(input int k);
    logic [31:0] target;
    target = srcCount + k;
    srcOn <= 1'b1;
    while (srcCount !== target) @(posedge clk_sys);
    srcOn <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic seeBlip(output logic s);
    s = 1'b0;
    repeat (12) begin
      @(posedge clk_sys);
      if (loopState === BLIP) s = 1'b1;
    end
  endtask

  task automatic clampChk(input logic [31:0] w, input logic [31:0] exp);
    loopWord <= w;
    repeat (3) @(posedge clk_sys);
    cmp(dcoWord, exp);
  endtask

  // ==========
  // Tests
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    cmp({phaseLock, freqLock}, 64'h0);
    xfer(14'h0A07, 1'b0, 32'h0000_0000);
    cmp(rd, 32'h0000_0000);
    xfer(14'h0A10, 1'b0, 32'h0000_0000);
    cmp({rd, er}, 64'h1);
    xfer(14'h0A10, 1'b1, 32'h0000_0001);
    cmp(er, 1'b1);
    wr(14'h0400, 32'h1234_5678);
    repeat (2) @(posedge clk_sys);
    cmp(dcoWord, 32'h1234_5678);
    wr(14'h0500, 32'h0BAD_F00D);
    cmp(freeRunWord1, 32'h0BAD_F00D);
    wr(14'h0444, 32'h0000_0005);
    wr(14'h0447, 32'h0000_0007);
    wr(14'h044A, 32'h0000_0009);
    wr(14'h046A, 32'h0000_0009);
    cmp(activeDiv, 64'h0);
    wr(14'h0005, 32'h0000_0001);
    repeat (3) @(posedge clk_sys);
    cmp(activeDiv, {17'h5, 23'h7, 23'h9});
    wr(14'h0A01, 32'h0000_0064);
    wr(14'h0A02, 32'h0000_0064);
    wr(14'h0A03, 32'h20FF_4040);
    refValid <= 4'h3;
    wr(14'h0A00, 32'h0000_0000);
    waitState(CLOSED);
    samples(48);
    cmp(phaseLock, 1'b0);
    samples(1);
    cmp({phaseLock, freqLock}, 64'h2);
    samples(51);
    wr(14'h0A00, 32'h0000_0004);
    repeat (8) @(posedge clk_sys);
    waitState(CLOSED);
    cmp({activeRef, phaseLock}, 64'h3);
    wr(14'h0467, 32'h0000_0003);
    wr(14'h0005, 32'h0000_0001);
    seeBlip(saw);
    cmp(saw, 1'b0);
    samples(1);
    cmp(activeDiv.fracNum, 23'h3);
    wr(14'h0464, 32'h0000_0002);
    wr(14'h0005, 32'h0000_0001);
    seeBlip(saw);
    cmp(saw, 1'b1);
    waitState(CLOSED);
    cmp({activeDiv.intDiv, phaseLock}, {17'h2, 1'b1});
    wr(14'h0A05, 32'h0000_1000);
    clampChk(32'h0000_5000, 32'h0000_1000);
    wr(14'h0A04, 32'h0000_0400);
    clampChk(32'h0000_0100, 32'h0000_0400);
    clampChk(32'h0000_0800, 32'h0000_0800);
    wr(14'h0A06, 32'h0000_0002);
    phaseMag <= 24'h000065;
    diffMag <= 24'h000032;
    samples(12);
    cmp(freqLock, 1'b0);
    samples(1);
    cmp(freqLock, 1'b1);
    samples(35);
    cmp(phaseLock, 1'b1);
    samples(1);
    cmp(phaseLock, 1'b0);
    wr(14'h0A00, 32'h0000_0005);
    waitState(HOLDOVER);
    repeat (2) @(posedge clk_sys);
    held = dcoWord;
    loopWord <= 32'h0000_0900;
    repeat (12) @(posedge clk_sys);
    cmp(dcoWord, held);
    cmp({loopState, phaseLock}, {HOLDOVER, 1'b0});
    cmp(dcoWord, 32'h0000_0800);
    xfer(14'h0A07, 1'b0, 32'h0000_0000);
    cmp(rd, 32'h0000_00A6);
    wr(14'h0A00, 32'h0000_0004);
    waitState(CLOSED);
    cmp(activeRef, 2'h1);
    finalReport();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    finalReport();
  end
endmodule // dpllc_loop_ctrl_bench
